// ===== include/aprc_map.svh
// Register map and timing constants of the analog power and reset control.
// Assumes a 100 MHz system clock and a 10-bit byte address on the bus.
`ifndef APRC_MAP_SVH
`define APRC_MAP_SVH

// Window bases for blocking and non-blocking accesses.
`define APRC_BASE_SEL_W     2
`define APRC_BASE_BLOCKING  2'h2
`define APRC_BASE_NONBLOCK  2'h3

// Printed register offsets, used as word indexes.
`define APRC_IDX_W          6
`define APRC_IDX_CTRL       6'h00
`define APRC_IDX_STAT       6'h02

// Control register fields.
`define APRC_CTL_TEMP_MASK  15
`define APRC_CTL_UV_MASK    14
`define APRC_CTL_RST_MASK   13
`define APRC_CTL_PF_MASK_HI 11
`define APRC_CTL_PF_MASK_LO 10
`define APRC_CTL_OM_MASK_HI 9
`define APRC_CTL_OM_MASK_LO 8
`define APRC_CTL_TEMP_GATE  7
`define APRC_CTL_UV_GATE    6
`define APRC_CTL_RST_CMD    5
`define APRC_CTL_PF_HI      3
`define APRC_CTL_PF_LO      2
`define APRC_CTL_OM_HI      1
`define APRC_CTL_OM_LO      0

// Status register fields.
`define APRC_ST_TEMP        7
`define APRC_ST_UV          6
`define APRC_ST_FORCED      5
`define APRC_ST_WDOG        4
`define APRC_ST_HREG        3
`define APRC_ST_LREG        2
`define APRC_ST_LIFE        1
`define APRC_ST_LPW         0

// Reset values and timing.
`define APRC_CTL_RESET      16'h0000
`define APRC_CLK_PERIOD_NS  10
`define APRC_RST_PULSE_NS   160
`define APRC_RST_PULSE_CYC  (`APRC_RST_PULSE_NS / `APRC_CLK_PERIOD_NS)
`define APRC_WAIT_BLOCKING  2'h1
`define APRC_WAIT_NONBLOCK  2'h0

`endif

// ===== include/aprc_pkg.sv
// Types shared by the analog power and reset control.
// Assumes the register map header is included alongside.
package aprc_pkg;

    // Operating mode codes as held in the control register.
    typedef enum logic [1:0] {
        APRC_MODE_NORMAL = 2'b00,
        APRC_MODE_STOP   = 2'b01,
        APRC_MODE_SLEEP  = 2'b10,
        APRC_MODE_CRANK  = 2'b11
    } aprc_op_mode_e;

    // Prescaler multiplier, one-hot of 1, 2, 4 or 8.
    typedef logic [3:0] aprc_mult_t;

endpackage : aprc_pkg

// ===== rtl/aprc_regs.sv
// Control and status registers of the analog die power, clock and reset unit.
// Assumes a synchronous Avalon-MM master and inputs synchronous to sys_clk.
`timescale 1ns/1ps
`include "aprc_map.svh"

module aprc_regs #(
    parameter int RST_PULSE_CYCLES = `APRC_RST_PULSE_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire logic [9:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   crank_enable,
    input  wire logic                   temp_warning,
    input  wire logic                   undervolt_warning,
    input  wire logic                   thermal_shutdown_reset,
    input  wire logic                   watchdog_reset,
    input  wire logic                   high_regulator_lowv,
    input  wire logic                   low_regulator_por,
    input  wire logic                   lifetime_wake,
    input  wire logic                   low_power_wake,
    input  wire logic                   reset_a_in,
    output logic                        reset_a_out,
    output logic                        reset_a_oe,
    output logic                        die_reset,
    output aprc_pkg::aprc_op_mode_e     op_mode,
    output aprc_pkg::aprc_mult_t        prescale_mult,
    output logic                        temp_irq_enable,
    output logic                        undervolt_irq_enable,
    output logic                        over_temp_interrupt,
    output logic                        undervolt_interrupt
);
    import aprc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Functions.

    // True when the byte address hits the given word index in a window.
    function automatic logic addr_hit(
        input logic [9:0]            addr,
        input logic [`APRC_IDX_W-1:0] idx
    );
        logic win;
        win = (addr[9:8] == `APRC_BASE_BLOCKING) ||
              (addr[9:8] == `APRC_BASE_NONBLOCK);
        return win && (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction : addr_hit

    // Multiplier applied to the 1.0 ms prescaler.
    function automatic aprc_mult_t pf_to_mult(input logic [1:0] pf);
        aprc_mult_t m;
        m = 4'h0;
        case (pf)
            2'h0:    m = 4'h1;
            2'h1:    m = 4'h2;
            2'h2:    m = 4'h4;
            default: m = 4'h8;
        endcase
        return m;
    endfunction : pf_to_mult

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [1:0]          wait_cnt_reg;
    logic [1:0]          wait_cnt_next;
    logic                wait_reg;
    logic                wait_next;
    logic [31:0]         rdata_reg;
    logic                temp_gate_reg;
    logic                uv_gate_reg;
    logic [1:0]          pf_reg;
    aprc_op_mode_e       mode_sel_reg;
    logic [15:0]         rst_cnt_reg;
    logic [15:0]         rst_cnt_next;
    logic                die_rst_reg;
    logic                pin_drive_reg;
    logic                temp_warn_d_reg;
    logic                uv_warn_d_reg;
    logic                temp_pend_reg;
    logic                uv_pend_reg;
    logic                tsd_last_reg;
    logic                forced_flag_reg;
    logic                wdog_flag_reg;
    logic                hreg_flag_reg;
    logic                lreg_flag_reg;
    logic                life_flag_reg;
    logic                lpw_flag_reg;
    aprc_op_mode_e       mode_out_reg;
    aprc_mult_t          mult_reg;
    logic                temp_en_reg;
    logic                uv_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // A request completes at the edge where waitrequest is seen low.
    wire        req        = avs_read | avs_write;
    wire        done       = req & ~wait_reg;
    wire        hit_ctrl   = addr_hit(avs_address, `APRC_IDX_CTRL);
    wire        hit_stat   = addr_hit(avs_address, `APRC_IDX_STAT);
    wire        blocking   = avs_address[9:8] == `APRC_BASE_BLOCKING;
    wire [1:0]  wait_limit = blocking ? `APRC_WAIT_BLOCKING
                                      : `APRC_WAIT_NONBLOCK;
    wire [15:0] wd         = avs_writedata[15:0];

    // Byte writes to the control word would tear the mask and data pair.
    wire ctrl_wr = done & avs_write & hit_ctrl & ~die_rst_reg &
                   (avs_byteenable[1:0] == 2'h3);
    wire stat_wr = done & avs_write & hit_stat & avs_byteenable[0];

    ////////////////////////////////////////////////////////////////////////
    // Control field writes.

    wire temp_gate_we = ctrl_wr & wd[`APRC_CTL_TEMP_MASK];
    wire uv_gate_we   = ctrl_wr & wd[`APRC_CTL_UV_MASK];
    wire pf_we        = ctrl_wr & wd[`APRC_CTL_PF_MASK_HI] &
                        wd[`APRC_CTL_PF_MASK_LO];
    wire mode_we      = ctrl_wr & wd[`APRC_CTL_OM_MASK_HI] &
                        wd[`APRC_CTL_OM_MASK_LO];
    wire forced_rst   = ctrl_wr & wd[`APRC_CTL_RST_MASK] &
                        wd[`APRC_CTL_RST_CMD];

    ////////////////////////////////////////////////////////////////////////
    // Reset generation.

    // The pin is ignored while we drive it, else our own pulse would loop.
    wire low_pwr_mode = (mode_sel_reg == APRC_MODE_STOP) ||
                        (mode_sel_reg == APRC_MODE_CRANK);
    wire ext_rst      = ~reset_a_in & ~pin_drive_reg & low_pwr_mode;
    wire pulse_start  = forced_rst | watchdog_reset;
    wire level_rst    = thermal_shutdown_reset | high_regulator_lowv |
                        low_regulator_por;
    wire pulse_busy   = rst_cnt_reg != 16'h0000;
    wire soft_rst     = pulse_start | pulse_busy | level_rst | ext_rst;

    // Pulse sources hold the pin for a fixed time, levels while present.
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        if (pulse_start) begin
            rst_cnt_next = RST_PULSE_CYCLES[15:0];
        end else if (pulse_busy) begin
            rst_cnt_next = rst_cnt_reg - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flag updates.

    // Status writes clear with a one; a zero leaves the flag alone.
    wire clr_temp   = stat_wr & wd[`APRC_ST_TEMP];
    wire clr_uv     = stat_wr & wd[`APRC_ST_UV];
    wire clr_forced = stat_wr & wd[`APRC_ST_FORCED];
    wire clr_wdog   = stat_wr & wd[`APRC_ST_WDOG];
    wire clr_hreg   = stat_wr & wd[`APRC_ST_HREG];
    wire clr_lreg   = stat_wr & wd[`APRC_ST_LREG];
    wire clr_life   = stat_wr & wd[`APRC_ST_LIFE];
    wire clr_lpw    = stat_wr & wd[`APRC_ST_LPW];

    // Interrupt flags rise with a warning while the gate bit is zero.
    wire temp_rise  = temp_warning & ~temp_warn_d_reg & ~temp_gate_reg;
    wire uv_rise    = undervolt_warning & ~uv_warn_d_reg & ~uv_gate_reg;
    wire temp_ack   = clr_temp & ~temp_warning;
    wire uv_ack     = clr_uv & ~undervolt_warning;

    // Read-back views of both registers.
    wire htf_view   = temp_warning | tsd_last_reg;
    wire uvf_view   = undervolt_warning;
    wire [15:0] ctrl_view = {8'h00, temp_gate_reg, uv_gate_reg,
                             2'h0, pf_reg, mode_sel_reg};
    wire [7:0]  stat_view = {htf_view, uvf_view, forced_flag_reg,
                             wdog_flag_reg, hreg_flag_reg, lreg_flag_reg,
                             life_flag_reg, lpw_flag_reg};
    wire [31:0] rd_mux    = hit_ctrl ? {16'h0000, ctrl_view} :
                            hit_stat ? {24'h000000, stat_view} :
                            32'h00000000;

    // Cranking code falls back to stop when the feature is off.
    wire aprc_op_mode_e mode_eff =
        (mode_sel_reg == APRC_MODE_CRANK && !crank_enable) ?
        APRC_MODE_STOP : mode_sel_reg;

    ////////////////////////////////////////////////////////////////////////
    // Handshake next state.

    // Blocking window gets one more wait cycle than non-blocking.
    always_comb begin
        wait_next     = 1'b1;
        wait_cnt_next = 2'h0;
        if (req && wait_reg) begin
            if (wait_cnt_reg == wait_limit) begin
                wait_next = 1'b0;
            end else begin
                wait_cnt_next = wait_cnt_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake and read data.

    // Read data loads together with waitrequest dropping.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg     <= 1'b1;
            wait_cnt_reg <= 2'h0;
            rdata_reg    <= 32'h00000000;
        end else begin
            wait_reg     <= wait_next;
            wait_cnt_reg <= wait_cnt_next;
            if (!wait_next && avs_read) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register.

    // Internal reset clears control, not the reset-source flags.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_gate_reg <= 1'b0;
            uv_gate_reg   <= 1'b0;
            pf_reg        <= 2'h0;
            mode_sel_reg  <= APRC_MODE_NORMAL;
        end else if (die_rst_reg) begin
            temp_gate_reg <= 1'b0;
            uv_gate_reg   <= 1'b0;
            pf_reg        <= 2'h0;
            mode_sel_reg  <= APRC_MODE_NORMAL;
        end else begin
            if (temp_gate_we) begin
                temp_gate_reg <= wd[`APRC_CTL_TEMP_GATE];
            end
            if (uv_gate_we) begin
                uv_gate_reg <= wd[`APRC_CTL_UV_GATE];
            end
            if (pf_we) begin
                pf_reg <= wd[`APRC_CTL_PF_HI:`APRC_CTL_PF_LO];
            end
            if (mode_we) begin
                mode_sel_reg <= aprc_op_mode_e'(
                    wd[`APRC_CTL_OM_HI:`APRC_CTL_OM_LO]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pulse and pin drive.

    // The pin is open drain: it only ever pulls low.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_reg   <= 16'h0000;
            die_rst_reg   <= 1'b0;
            pin_drive_reg <= 1'b0;
        end else begin
            rst_cnt_reg   <= rst_cnt_next;
            die_rst_reg   <= soft_rst;
            pin_drive_reg <= pulse_start | (rst_cnt_next != 16'h0000) |
                             level_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags and warning edges.

    // Set wins over a clear in the same cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_warn_d_reg <= 1'b0;
            uv_warn_d_reg   <= 1'b0;
            temp_pend_reg   <= 1'b0;
            uv_pend_reg     <= 1'b0;
        end else begin
            temp_warn_d_reg <= temp_warning;
            uv_warn_d_reg   <= undervolt_warning;
            temp_pend_reg   <= temp_rise |
                               (temp_pend_reg & ~temp_ack & ~die_rst_reg);
            uv_pend_reg     <= uv_rise |
                               (uv_pend_reg & ~uv_ack & ~die_rst_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-source flags.

    // These persist through the internal reset they report.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tsd_last_reg    <= 1'b0;
            forced_flag_reg <= 1'b0;
            wdog_flag_reg   <= 1'b0;
            hreg_flag_reg   <= 1'b0;
            lreg_flag_reg   <= 1'b0;
        end else begin
            tsd_last_reg    <= thermal_shutdown_reset |
                               (tsd_last_reg & ~clr_temp);
            forced_flag_reg <= forced_rst |
                               (forced_flag_reg & ~clr_forced);
            wdog_flag_reg   <= watchdog_reset |
                               (wdog_flag_reg & ~clr_wdog);
            hreg_flag_reg   <= high_regulator_lowv | low_regulator_por |
                               (hreg_flag_reg & ~clr_hreg);
            lreg_flag_reg   <= low_regulator_por |
                               (lreg_flag_reg & ~clr_lreg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up flags.

    // Wake causes are not reset sources, so internal reset clears them.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            life_flag_reg <= 1'b0;
            lpw_flag_reg  <= 1'b0;
        end else begin
            life_flag_reg <= lifetime_wake | (life_flag_reg &
                             ~clr_life & ~die_rst_reg);
            lpw_flag_reg  <= low_power_wake | (lpw_flag_reg &
                             ~clr_lpw & ~die_rst_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs toward the analog die.

    // Gate bits are inverted into active-high enables.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_out_reg <= APRC_MODE_NORMAL;
            mult_reg     <= 4'h1;
            temp_en_reg  <= 1'b0;
            uv_en_reg    <= 1'b0;
        end else begin
            mode_out_reg <= mode_eff;
            mult_reg     <= pf_to_mult(pf_reg);
            temp_en_reg  <= ~temp_gate_reg;
            uv_en_reg    <= ~uv_gate_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port assignments.

    assign avs_readdata         = rdata_reg;
    assign avs_waitrequest      = wait_reg;
    assign reset_a_out          = 1'b0;
    assign reset_a_oe           = pin_drive_reg;
    assign die_reset            = die_rst_reg;
    assign op_mode              = mode_out_reg;
    assign prescale_mult        = mult_reg;
    assign temp_irq_enable      = temp_en_reg;
    assign undervolt_irq_enable = uv_en_reg;
    assign over_temp_interrupt  = temp_pend_reg;
    assign undervolt_interrupt  = uv_pend_reg;

endmodule : aprc_regs

// ===== tb/aprc_regs_checker.sv
// Port-level checks of the power and reset control registers.
// Assumes binding into every register block instance.
`timescale 1ns/1ps
module aprc_regs_checker #(
    parameter int RST_PULSE_CYCLES = 16
) (
    input wire logic                    sys_clk,
    input wire logic                    arst_n,
    input wire logic [9:0]              avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_writedata,
    input wire logic [3:0]              avs_byteenable,
    input wire logic [31:0]             avs_readdata,
    input wire logic                    avs_waitrequest,
    input wire logic                    crank_enable,
    input wire logic                    reset_a_in,
    input wire logic                    reset_a_oe,
    input wire logic                    die_reset,
    input wire aprc_pkg::aprc_op_mode_e op_mode,
    input wire aprc_pkg::aprc_mult_t    prescale_mult,
    input wire logic                    temp_irq_enable,
    input wire logic                    undervolt_irq_enable
);
    import aprc_pkg::*;
    logic [7:0] len_reg;
    logic       fcause_reg;
    // Decode of completed control accesses.
    wire logic ctl_hit = avs_address[9] && avs_address[7:0] == 8'h00;
    wire logic ctl_wr  = avs_write && !avs_waitrequest && ctl_hit &&
                         avs_byteenable[1:0] == 2'b11 && !die_reset;
    wire logic ctl_rd  = avs_read && !avs_waitrequest && ctl_hit;
    wire logic fwr     = ctl_wr && avs_writedata[13] && avs_writedata[5];
    // Length of the die reset; forced and watchdog ones have a fixed length, only a forced one is tracked.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            len_reg    <= 8'h00;
            fcause_reg <= 1'b0;
        end else begin
            len_reg    <= die_reset ? len_reg + 8'h01 : 8'h00;
            fcause_reg <= fwr || (fcause_reg && die_reset);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Both the die and the pin go into reset shortly after the write.
    sequence s_rst_on;
        ##[1:2] (die_reset && reset_a_oe);
    endsequence
    a_answer_req: assert property (!avs_waitrequest |->
        (avs_read || avs_write) ##1 avs_waitrequest)
        else $error("answer without request or too long");
    a_block_wait: assert property (!avs_waitrequest &&
        avs_address[9:8] == 2'h2 |-> $past(avs_waitrequest) &&
        $past(avs_read || avs_write, 2))
        else $error("blocking window answered early");
    a_ctl_zeros: assert property (ctl_rd |->
        avs_readdata[31:8] == 24'h0 && avs_readdata[5:4] == 2'b00)
        else $error("control read shows write-only bits");
    a_temp_gate: assert property (ctl_wr && avs_writedata[15] &&
        avs_writedata[7] |-> ##[1:3] !temp_irq_enable)
        else $error("temperature gate write not effective");
    a_uv_gate: assert property (ctl_wr && avs_writedata[14] &&
        !avs_writedata[6] |-> ##[1:3] undervolt_irq_enable)
        else $error("undervoltage gate write not effective");
    a_forced_rst: assert property (fwr |-> s_rst_on)
        else $error("forced reset did not start");
    a_pulse_len: assert property ($fell(die_reset) && fcause_reg |->
        len_reg == RST_PULSE_CYCLES + 1)
        else $error("forced reset length wrong");
    a_crank_en: assert property (op_mode == APRC_MODE_CRANK |->
        $past(crank_enable))
        else $error("cranking without the feature enabled");
    a_pin_reset: assert property (!reset_a_in && !reset_a_oe &&
        (op_mode == APRC_MODE_STOP || op_mode == APRC_MODE_CRANK)
        |=> die_reset)
        else $error("pin reset ignored in low power mode");
    a_mult_onehot: assert property ($onehot(prescale_mult))
        else $error("prescale multiplier not a power of two");
endmodule : aprc_regs_checker

bind aprc_regs aprc_regs_checker #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .crank_enable(crank_enable), .reset_a_in(reset_a_in),
    .reset_a_oe(reset_a_oe), .die_reset(die_reset), .op_mode(op_mode),
    .prescale_mult(prescale_mult), .temp_irq_enable(temp_irq_enable),
    .undervolt_irq_enable(undervolt_irq_enable));

// ===== tb/aprc_regs_bench.sv
// Self-checking bench of the power and reset control registers.
// Assumes the design headers and package are compiled first.
`timescale 1ns/1ps
module aprc_regs_bench;
    import aprc_pkg::*;
    logic          sys_clk, arst_n, avs_read, avs_write, crank_enable;
    logic [9:0]    avs_address;
    logic [31:0]   avs_writedata, avs_readdata, q;
    logic [3:0]    avs_byteenable, be;
    logic          avs_waitrequest, temp_warning, undervolt_warning;
    logic          thermal_shutdown_reset, watchdog_reset, pin_ext;
    logic          high_regulator_lowv, low_regulator_por, lifetime_wake;
    logic          low_power_wake, reset_a_out, reset_a_oe, die_reset;
    logic          temp_irq_enable, undervolt_irq_enable, g7, g6;
    logic          over_temp_interrupt, undervolt_interrupt;
    logic [15:0]   d;
    logic [1:0]    om, pf;
    aprc_op_mode_e op_mode;
    aprc_mult_t    prescale_mult;
    int            bad_count, n_compared, seed;
    // Open-drain reset pin: the block pulls low, else the outside level.
    wire logic reset_a_in = reset_a_oe ? reset_a_out : pin_ext;
    localparam logic [7:0] SRC_EXP [6] = '{8'h20, 8'h10, 8'h08, 8'h0C,
                                           8'h80, 8'h03};
    aprc_regs #(.RST_PULSE_CYCLES(2)) DUT (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // Mode code 11 falls back to stop when cranking is not available.
    function automatic logic [1:0] exp_mode(logic [1:0] m, logic c);
        return (m == 2'b11 && !c) ? 2'b01 : m;
    endfunction : exp_mode
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One bus transfer; held until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [15:0] wd, input logic [3:0] b);
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= {16'h0000, wd};
        avs_byteenable <= b;
        avs_write      <= wr;
        avs_read       <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Waits out a die reset; one that never ends trips the watchdog.
    task automatic settle();
        while (die_reset !== 1'b0) @(negedge sys_clk);
    endtask : settle
    task automatic src_case(input int k, input logic [7:0] e);
        bus(1'b1, 10'h308, 16'h00FF, 4'hF);
        bus(1'b1, 10'h300, 16'hCF08, 4'hF);
        case (k)
            0: bus(1'b1, 10'h200, 16'h2020, 4'hF);
            1: watchdog_reset <= 1'b1;
            2: high_regulator_lowv <= 1'b1;
            3: low_regulator_por <= 1'b1;
            4: thermal_shutdown_reset <= 1'b1;
            default: {lifetime_wake, low_power_wake} <= 2'b11;
        endcase
        @(posedge sys_clk);
        {watchdog_reset, lifetime_wake, low_power_wake} <= '0;
        repeat (3) @(posedge sys_clk);
        {high_regulator_lowv, low_regulator_por, thermal_shutdown_reset} <= '0;
        @(negedge sys_clk) settle();
        bus(1'b0, 10'h300, 16'h0000, 4'hF);
        chk("ctrl_after", q, (k == 5) ? 32'h8 : 32'h0);
        bus(1'b1, 10'h308, 16'h0000, 4'hF);
        bus(1'b0, 10'h208, 16'h0000, 4'hF);
        chk("status", q, {24'h0, e});
        bus(1'b1, 10'h208, {8'h00, e}, 4'hF);
        bus(1'b0, 10'h308, 16'h0000, 4'hF);
        chk("status_clr", q, 32'h0);
    endtask : src_case
    task automatic warn_check(input logic [7:0] st, input logic irq);
        bus(1'b0, 10'h308, 16'h0000, 4'hF);
        chk("warn_status", q, {24'h0, st});
        chk("temp_irq", over_temp_interrupt, irq);
        chk("uv_irq", undervolt_interrupt, irq);
    endtask : warn_check
    task automatic pin_try(input logic e);
        @(posedge sys_clk) pin_ext <= 1'b0;
        @(posedge sys_clk) pin_ext <= 1'b1;
        @(negedge sys_clk) chk("pin_rst", die_reset, e);
        settle();
    endtask : pin_try
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized at 20000 cycles, well beyond the under one thousand cycles the run needs.
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    // Main sequence: reset, masked writes, reset sources, warnings, pin.
    initial begin
        seed = 32'h3B52;
        {avs_read, avs_write, crank_enable, temp_warning} = '0;
        {undervolt_warning, thermal_shutdown_reset, watchdog_reset} = '0;
        {high_regulator_lowv, low_regulator_por, lifetime_wake} = '0;
        {low_power_wake, g7, g6, om, pf, arst_n} = '0;
        {avs_address, avs_writedata, avs_byteenable} = '0;
        {pin_ext, bad_count, n_compared} = '0;
        pin_ext = 1'b1;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(1'b0, 10'h200, 16'h0000, 4'hF);
        chk("ctrl_rst", q, 32'h0);
        chk("temp_en_rst", temp_irq_enable, 1'b1);
        for (int i = 0; i < 48; i++) begin
            d = 16'($random(seed));
            be = (i % 6 == 5) ? 4'h1 : 4'hF;
            if (i < 8) d[11:0] = {4'hF, d[7:4], i[1:0], i[1:0]};
            d[12] = 1'b0;
            d[4] = 1'b0;
            if (d[5]) d[13] = 1'b0;
            if (be[1:0] == 2'b11) begin
                if (d[15]) g7 = d[7];
                if (d[14]) g6 = d[6];
                if (d[11:10] == 2'b11) pf = d[3:2];
                if (d[9:8] == 2'b11) om = d[1:0];
            end
            bus(1'b1, {1'b1, d[0], 8'h00}, d, be);
            crank_enable <= i[2];
            bus(1'b0, {1'b1, d[1], 8'h00}, 16'h0000, 4'hF);
            @(negedge sys_clk);
            chk("ctrl", q, {24'h0, g7, g6, 2'b00, pf, om});
            chk("mult", prescale_mult, 4'h1 << pf);
            chk("mode", op_mode, exp_mode(om, i[2]));
            chk("temp_en", temp_irq_enable, !g7);
            chk("uv_en", undervolt_irq_enable, !g6);
            chk("no_rst", die_reset, 1'b0);
        end
        bus(1'b0, 10'h104, 16'h0000, 4'hF);
        chk("unmapped", q, 32'h0);
        for (int k = 0; k < 6; k++) src_case(k, SRC_EXP[k]);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, 10'h300, j ? 16'hC0C0 : 16'hC000, 4'hF);
            {temp_warning, undervolt_warning} <= 2'b11;
            warn_check(8'hC0, !j);
            bus(1'b1, 10'h308, 16'h00C0, 4'hF);
            warn_check(8'hC0, !j);
            {temp_warning, undervolt_warning} <= 2'b00;
            warn_check(8'h00, !j);
            bus(1'b1, 10'h208, 16'h00C0, 4'hF);
            warn_check(8'h00, 1'b0);
        end
        bus(1'b1, 10'h300, 16'h0301, 4'hF);
        pin_try(1'b1);
        pin_try(1'b0);
        summarize();
    end
endmodule : aprc_regs_bench
